// ===== psc_power_save.sv
// power-save mode controller, slowed cpu clock and per-module clock gating
`timescale 1ns/1ns
module psc_power_save #(
   parameter logic [28:0] PRESENT = psc_pkg::PRESENT_ALL
) (
   input  wire logic                         clk,
   input  wire logic                         rst_b,
   input  wire logic [3:0]                   addr,
   input  wire logic [15:0]                  wdata,
   input  wire logic                         wr,
   input  wire logic                         rd,
   output logic      [15:0]                  rdata_q,
   input  wire logic                         power_save_instruction,
   input  wire logic                         save_op_sleep,
   input  wire logic                         irq_pending,
   input  wire logic                         soft_reset,
   input  wire logic                         wdt_timeout,
   input  wire logic                         watchdog_timer_en,
   input  wire logic                         clock_failure_monitor_en,
   input  wire logic [2:0]                   next_clock_source,
   output logic                              osc_enable_q,
   output logic                              low_power_rc_clock_en_q,
   output logic                              monitor_active_q,
   output logic                              wdt_clear_q,
   output logic                              cpu_halted_q,
   output logic                              cpu_resume_q,
   output logic                              resume_isr_q,
   output logic      [2:0]                   clk_src_q,
   output logic                              analog_off_q,
   output logic      [psc_pkg::N_PERIPH-1:0] sfr_en_q,
   output wire logic                         cpu_clk,
   output wire logic [psc_pkg::N_PERIPH-1:0] periph_clk
);
   import psc_pkg::*;

   psc_state_t       state_q;
   psc_state_t       state_d;
   logic             sleep_op_q;
   logic             pend_q;
   logic [1:0]       wake_cnt_q;
   logic             wdt_to_m_q;
   logic             wdt_to_s_q;
   logic [15:0]      clock_divider_register_q;
   logic [15:0]      module_disable_ctrl_1_q;
   logic [15:0]      module_disable_ctrl_2_q;
   logic [N_PERIPH-1:0] run_q;
   logic             cpu_en_q;
   logic             doze_tick;
   logic             wake_evt;
   logic             roi_clear;
   logic             wr_div;
   logic [N_PERIPH-1:0] off_vec;

   // watchdog time-out comes from the rc clock domain
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wdt_to_m_q <= 1'b0;
         wdt_to_s_q <= 1'b0;
      end else begin
         wdt_to_m_q <= wdt_timeout;
         wdt_to_s_q <= wdt_to_m_q;
      end
   end

   assign wake_evt = irq_pending | pend_q | wdt_to_s_q | soft_reset;
   assign wr_div   = wr && (addr == ADDR_DIV);

   // power-save sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (power_save_instruction) begin
               state_d = ST_ENTER;
            end
         end
         ST_ENTER: begin
            state_d = sleep_op_q ? ST_SLEEP : ST_IDLE;
         end
         ST_SLEEP, ST_IDLE: begin
            if (wake_evt) begin
               state_d = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (wake_cnt_q == 2'h0) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_op_q <= 1'b0;
      end else if (state_q == ST_RUN && power_save_instruction) begin
         sleep_op_q <= save_op_sleep;
      end
   end

   // an interrupt seen during entry is held and wakes right after entry
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_q <= 1'b0;
      end else if (state_q == ST_ENTER && irq_pending) begin
         pend_q <= 1'b1;
      end else if (state_q == ST_WAKE) begin
         pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_cnt_q <= 2'h0;
      end else if (state_d == ST_WAKE && state_q != ST_WAKE) begin
         wake_cnt_q <= WAKE_CYCLES - 2'h1;
      end else if (wake_cnt_q != 2'h0) begin
         wake_cnt_q <= wake_cnt_q - 2'h1;
      end
   end

   // resume pulse and where the cpu restarts
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu_resume_q <= 1'b0;
         resume_isr_q <= 1'b0;
      end else begin
         cpu_resume_q <= (state_q == ST_WAKE) && (state_d == ST_RUN);
         if ((state_q == ST_SLEEP || state_q == ST_IDLE) && wake_evt) begin
            resume_isr_q <= irq_pending | pend_q;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu_halted_q <= 1'b0;
      end else begin
         cpu_halted_q <= (state_d != ST_RUN);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wdt_clear_q <= 1'b0;
      end else begin
         wdt_clear_q <= (state_q == ST_RUN) && power_save_instruction
                        && watchdog_timer_en;
      end
   end

   // oscillator, rc clock and failure monitor enables
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         osc_enable_q            <= 1'b1;
         low_power_rc_clock_en_q <= 1'b0;
         monitor_active_q        <= 1'b0;
      end else begin
         osc_enable_q     <= (state_d != ST_SLEEP);
         monitor_active_q <= clock_failure_monitor_en && (state_d != ST_SLEEP);
         if (state_d == ST_SLEEP) begin
            low_power_rc_clock_en_q <= watchdog_timer_en;
         end else begin
            low_power_rc_clock_en_q <= watchdog_timer_en | clock_failure_monitor_en;
         end
      end
   end

   // source is frozen through sleep so wake returns to it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_src_q <= 3'h0;
      end else if (state_q == ST_RUN && state_d == ST_RUN) begin
         clk_src_q <= next_clock_source;
      end
   end

   // divider register; a pending interrupt with ROI set clears the enable, a write setting it wins
   assign roi_clear = irq_pending && clock_divider_register_q[ROI_BIT]
                      && clock_divider_register_q[DOZE_EN_BIT];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clock_divider_register_q <= DIV_RESET;
      end else if (wr_div) begin
         clock_divider_register_q <= psc_wmerge(clock_divider_register_q, wdata, DIV_WMASK);
      end else if (roi_clear) begin
         clock_divider_register_q[DOZE_EN_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         module_disable_ctrl_1_q <= MDC_RESET;
         module_disable_ctrl_2_q <= MDC_RESET;
      end else if (wr && addr == ADDR_MDC1) begin
         module_disable_ctrl_1_q <= psc_wmerge(module_disable_ctrl_1_q, wdata, MDC1_WMASK);
      end else if (wr && addr == ADDR_MDC2) begin
         module_disable_ctrl_2_q <= psc_wmerge(module_disable_ctrl_2_q, wdata, MDC2_WMASK);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 16'h0000;
      end else if (rd) begin
         case (addr)
            ADDR_DIV:  rdata_q <= clock_divider_register_q;
            ADDR_MDC1: rdata_q <= module_disable_ctrl_1_q;
            ADDR_MDC2: rdata_q <= module_disable_ctrl_2_q;
            ADDR_STAT: rdata_q <= {8'h00, clk_src_q, state_q};
            default:   rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   // slowed cpu clock: ticks fall on system edges, domains stay aligned
   psc_doze_div u_div (
      .clk   (clk),
      .rst_b (rst_b),
      .ratio (clock_divider_register_q[RATIO_HI:RATIO_LO]),
      .tick  (doze_tick)
   );

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu_en_q <= 1'b0;
      end else if (state_d != ST_RUN) begin
         cpu_en_q <= 1'b0;
      end else if (clock_divider_register_q[DOZE_EN_BIT]) begin
         cpu_en_q <= doze_tick;
      end else begin
         cpu_en_q <= 1'b1;
      end
   end

   psc_clk_gate u_cpu_gate (
      .clk   (clk),
      .rst_b (rst_b),
      .en    (cpu_en_q),
      .gclk  (cpu_clk)
   );

   // module enables follow the disable bits one cycle after the register
   assign off_vec = psc_off_vec(module_disable_ctrl_1_q, module_disable_ctrl_2_q);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sfr_en_q     <= '0;
         analog_off_q <= 1'b0;
      end else begin
         sfr_en_q     <= PRESENT & ~off_vec;
         analog_off_q <= off_vec[ADC_IDX];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         run_q <= '0;
      end else if (state_d == ST_SLEEP) begin
         run_q <= '0;
      end else begin
         run_q <= PRESENT & ~off_vec;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < N_PERIPH; gi++) begin : g_gate
         psc_clk_gate u_gate (
            .clk   (clk),
            .rst_b (rst_b),
            .en    (run_q[gi]),
            .gclk  (periph_clk[gi])
         );
      end
   endgenerate

   property p_sleep_osc;
      @(posedge clk) disable iff (!rst_b)
         (state_q == ST_SLEEP) |-> !osc_enable_q && (run_q == '0) && !cpu_en_q;
   endproperty
   a_sleep_osc: assert property (p_sleep_osc) else $error("clocks running in sleep");

   property p_monitor_off;
      @(posedge clk) disable iff (!rst_b)
         (state_q == ST_SLEEP) |-> !monitor_active_q;
   endproperty
   a_monitor_off: assert property (p_monitor_off) else $error("monitor active in sleep");

   property p_rc_sleep;
      @(posedge clk) disable iff (!rst_b)
         (state_q == ST_SLEEP && $past(watchdog_timer_en))
         |-> low_power_rc_clock_en_q;
   endproperty
   a_rc_sleep: assert property (p_rc_sleep) else $error("rc clock off in sleep");

   property p_wdt_clear;
      @(posedge clk) disable iff (!rst_b)
         (state_q == ST_RUN && power_save_instruction && watchdog_timer_en)
         |=> wdt_clear_q && state_q == ST_ENTER;
   endproperty
   a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared on entry");

   property p_idle_wake;
      @(posedge clk) disable iff (!rst_b)
         (state_q == ST_IDLE && irq_pending)
         |=> state_q == ST_WAKE ##3 cpu_resume_q && resume_isr_q;
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle wake timing wrong");

   property p_defer;
      @(posedge clk) disable iff (!rst_b)
         (state_q == ST_ENTER && irq_pending)
         |=> (state_q == ST_SLEEP || state_q == ST_IDLE) ##1 state_q == ST_WAKE;
   endproperty
   a_defer: assert property (p_defer) else $error("entry interrupt not deferred");

   property p_roi;
      @(posedge clk) disable iff (!rst_b)
         (roi_clear && !wr_div) |=> !clock_divider_register_q[DOZE_EN_BIT] ##1 cpu_en_q
         || state_q != ST_RUN;
   endproperty
   a_roi: assert property (p_roi) else $error("interrupt did not end doze");

   property p_md_delay;
      @(posedge clk) disable iff (!rst_b)
         (wr && addr == ADDR_MDC1 && wdata[0])
         |=> module_disable_ctrl_1_q[0] ##1 !sfr_en_q[ADC_IDX] && analog_off_q;
   endproperty
   a_md_delay: assert property (p_md_delay) else $error("module disable delay wrong");

   property p_reserved;
      @(posedge clk) disable iff (!rst_b)
         1'b1 |-> module_disable_ctrl_1_q[10:8] == 3'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set");
endmodule : psc_power_save

// ===== psc_pkg.sv
// constants, types and helpers shared by the power-save clock controller
package psc_pkg;
   localparam logic [3:0]  ADDR_DIV      = 4'h0;
   localparam logic [3:0]  ADDR_MDC1     = 4'h2;
   localparam logic [3:0]  ADDR_MDC2     = 4'h4;
   localparam logic [3:0]  ADDR_STAT     = 4'h6;
   localparam int          ROI_BIT       = 15;
   localparam int          RATIO_HI      = 14;
   localparam int          RATIO_LO      = 12;
   localparam int          DOZE_EN_BIT   = 11;
   localparam logic [15:0] DIV_WMASK     = 16'hf800;
   localparam logic [15:0] MDC1_WMASK    = 16'hf8ff;
   localparam logic [15:0] MDC2_WMASK    = 16'hffff;
   localparam logic [15:0] DIV_RESET     = 16'h0000;
   localparam logic [15:0] MDC_RESET     = 16'h0000;
   localparam int          N_PERIPH      = 29;
   localparam int          ADC_IDX       = 0;
   localparam int          DIV_W         = 7;
   localparam logic [1:0]  WAKE_CYCLES   = 2'h3;
   localparam logic [28:0] PRESENT_ALL   = 29'h1fffffff;

   typedef enum logic [4:0] {
      ST_RUN   = 5'h01,
      ST_ENTER = 5'h02,
      ST_SLEEP = 5'h04,
      ST_IDLE  = 5'h08,
      ST_WAKE  = 5'h10
   } psc_state_t;

   // disable vector: {capture 8..1, compare 8..1, timer 5..1, i2c .. adc}
   function automatic logic [28:0] psc_off_vec(input logic [15:0] m1, input logic [15:0] m2);
      psc_off_vec = {m2, m1[15:11], m1[7:0]};
   endfunction : psc_off_vec

   // masked register write: only writable bits take the new value
   function automatic logic [15:0] psc_wmerge(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [15:0] mask);
      psc_wmerge = (old_v & ~mask) | (new_v & mask);
   endfunction : psc_wmerge
endpackage : psc_pkg

// ===== psc_clk_gate.sv
// glitch-free clock gate with enable held on the low phase
`timescale 1ns/1ns
module psc_clk_gate (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic en,
   output wire logic gclk
);
   import psc_pkg::*;

   logic en_q;

   // enable changes only while clk is low, so high pulses are never cut
   always_ff @(negedge clk or negedge rst_b) begin
      if (!rst_b) begin
         en_q <= 1'b0;
      end else begin
         en_q <= en;
      end
   end

   assign gclk = clk & en_q;
endmodule : psc_clk_gate

// ===== psc_doze_div.sv
// cpu clock enable divider for the slowed cpu mode
`timescale 1ns/1ns
module psc_doze_div (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic [2:0] ratio,
   output wire logic       tick
);
   import psc_pkg::*;

   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] mask;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 7'h01;
      end
   end

   // tick once every 2^ratio system cycles, on a system edge
   assign mask = DIV_W'((8'h01 << ratio) - 8'h01);
   assign tick = ((cnt_q & mask) == '0);

   property p_div_half;
      @(posedge clk) disable iff (!rst_b)
         (ratio == 3'h1 && tick) ##1 (ratio == 3'h1)
         |-> !tick ##1 (tick || ratio != 3'h1);
   endproperty
   a_div_half: assert property (p_div_half) else $error("ratio 1:2 tick spacing wrong");
endmodule : psc_doze_div

// ===== psc_periph_model.sv
// behavioural model of the cpu core and one selected peripheral counting the clocks they are given
`timescale 1ns/1ns
module psc_periph_model (
   input  wire logic                         cpu_clk,
   input  wire logic [psc_pkg::N_PERIPH-1:0] periph_clk,
   input  wire logic [4:0]                   sel,
   input  wire logic                         clr,
   output logic      [15:0]                  cpu_cnt,
   output logic      [15:0]                  per_cnt
);
   import psc_pkg::*;
   wire logic pclk;
   // one watched peripheral at a time, chosen while its clock is settled
   assign pclk = periph_clk[sel];
   // the core only advances on the edges it receives
   always_ff @(posedge cpu_clk or posedge clr) begin
      if (clr) begin
         cpu_cnt <= 16'h0000;
      end else begin
         cpu_cnt <= cpu_cnt + 16'h0001;
      end
   end
   always_ff @(posedge pclk or posedge clr) begin
      if (clr) begin
         per_cnt <= 16'h0000;
      end else begin
         per_cnt <= per_cnt + 16'h0001;
      end
   end
endmodule : psc_periph_model

// ===== tb_power_save_clock_gating.sv
// self-checking bench for the power-save clock controller
`timescale 1ns/1ns
module tb_power_save_clock_gating;
   import psc_pkg::*;
   logic                clk = 1'b0;
   logic                rst_b = 1'b0;
   logic [3:0]          addr = 4'h0;
   logic [15:0]         wdata = 16'h0000;
   logic                wr = 1'b0;
   logic                rd = 1'b0;
   logic [15:0]         rdata_q;
   logic                power_save_instruction = 1'b0;
   logic                save_op_sleep = 1'b0;
   logic                irq_pending = 1'b0;
   logic                soft_reset = 1'b0;
   logic                wdt_timeout = 1'b0;
   logic                watchdog_timer_en = 1'b0;
   logic                clock_failure_monitor_en = 1'b0;
   logic [2:0]          next_clock_source = 3'h5;
   logic                osc_enable_q;
   logic                low_power_rc_clock_en_q;
   logic                monitor_active_q;
   logic                wdt_clear_q;
   logic                cpu_halted_q;
   logic                cpu_resume_q;
   logic                resume_isr_q;
   logic [2:0]          clk_src_q;
   logic                analog_off_q;
   logic [N_PERIPH-1:0] sfr_en_q;
   logic                cpu_clk;
   logic [N_PERIPH-1:0] periph_clk;
   logic [4:0]          sel = 5'd8;
   logic                clr = 1'b0;
   logic [15:0]         cpu_cnt;
   logic [15:0]         per_cnt;
   int                  n_mismatch = 0;
   int                  comparisons = 0;

   psc_power_save dut (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata_q,
      .power_save_instruction, .save_op_sleep, .irq_pending, .soft_reset, .wdt_timeout,
      .watchdog_timer_en, .clock_failure_monitor_en, .next_clock_source, .osc_enable_q,
      .low_power_rc_clock_en_q, .monitor_active_q, .wdt_clear_q, .cpu_halted_q,
      .cpu_resume_q, .resume_isr_q, .clk_src_q, .analog_off_q, .sfr_en_q, .cpu_clk,
      .periph_clk);
   psc_periph_model model (.cpu_clk, .periph_clk, .sel, .clr, .cpu_cnt, .per_cnt);

   always #20 clk = ~clk;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata_q;
   endtask : rd_reg

   // clears both counters just after an edge, then lets cyc edges pass
   task automatic measure(input int cyc);
      @(posedge clk);
      #1 clr = 1'b1;
      #1 clr = 1'b0;
      repeat (cyc) @(posedge clk);
      #1;
   endtask : measure

   task automatic t_regs;
      logic [15:0] d;
      logic [3:0]  a;
      logic [15:0] exp [4] = '{16'hf800, 16'hf8ff, 16'hffff, 16'h0000};
      #1 check("run_all", 32'(sfr_en_q), 32'(PRESENT_ALL));
      rd_reg(ADDR_STAT, d);
      check("status", 32'(d), 32'({8'h00, 3'h5, ST_RUN}));
      for (int i = 0; i < 4; i++) begin
         a = (i == 3) ? 4'he : 4'(2 * i);
         rd_reg(a, d);
         check("reset_val", 32'(d), 32'h0);
         wr_reg(a, 16'hffff);
         rd_reg(a, d);
         check("reg_mask", 32'(d), 32'(exp[i]));
      end
      check("all_off", 32'(sfr_en_q), 32'h0);
      check("analog", 32'(analog_off_q), 32'h1);
      for (int i = 0; i < 3; i++) begin
         wr_reg(4'(2 * i), 16'h0000);
      end
   endtask : t_regs

   task automatic t_map;
      logic [15:0] m1;
      logic [15:0] m2;
      logic [28:0] prev;
      logic [28:0] exp;
      prev = PRESENT_ALL;
      for (int i = 0; i < 32; i++) begin
         m1 = (i < 16) ? 16'h0001 << i : 16'h0000;
         m2 = (i < 16) ? 16'h0000 : 16'h0001 << (i - 16);
         exp = PRESENT_ALL & ~{m2, m1[15:11], m1[7:0]};
         wr_reg((i < 16) ? ADDR_MDC1 : ADDR_MDC2, (i < 16) ? m1 : m2);
         #1 check("en_lag", 32'(sfr_en_q), 32'(prev));
         @(posedge clk);
         #1 check("en_map", 32'(sfr_en_q), 32'(exp));
         check("analog", 32'(analog_off_q), 32'(m1[0]));
         prev = exp;
         if (i == 15) begin
            wr_reg(ADDR_MDC1, 16'h0000);
            prev = PRESENT_ALL;
         end
      end
      wr_reg(ADDR_MDC2, 16'h0000);
   endtask : t_map

   task automatic t_clkstop;
      wr_reg(ADDR_MDC1, 16'h0001);
      sel = 5'd0;
      measure(8);
      check("adc_clk_off", 32'(per_cnt), 32'h0);
      sel = 5'd8;
      measure(8);
      check("tmr_clk_on", 32'(per_cnt), 32'd8);
      wr_reg(ADDR_MDC1, 16'h0000);
      sel = 5'd0;
      measure(8);
      check("adc_clk_back", 32'(per_cnt), 32'd8);
      sel = 5'd8;
   endtask : t_clkstop

   task automatic pulse_irq;
      @(posedge clk);
      irq_pending <= 1'b1;
      repeat (2) @(posedge clk);
      irq_pending <= 1'b0;
   endtask : pulse_irq

   task automatic t_doze;
      logic [15:0] d;
      int          e;
      for (int n = 0; n < 8; n++) begin
         wr_reg(ADDR_DIV, 16'h0800 | (16'(n) << 12));
         measure(256);
         e = 256 >> n;
         check("cpu_rate", 32'(int'(cpu_cnt) >= e - 1 && int'(cpu_cnt) <= e + 1), 32'h1);
         check("per_rate", 32'(per_cnt), 32'd256);
      end
      wr_reg(ADDR_DIV, 16'hb800);
      pulse_irq();
      rd_reg(ADDR_DIV, d);
      check("roi_clears", 32'(d), 32'h0000b000);
      wr_reg(ADDR_DIV, 16'h3800);
      pulse_irq();
      rd_reg(ADDR_DIV, d);
      check("no_roi", 32'(d), 32'h00003800);
      wr_reg(ADDR_DIV, 16'h7000);
      measure(64);
      check("doze_off", 32'(cpu_cnt), 32'd64);
      wr_reg(ADDR_DIV, 16'h0000);
   endtask : t_doze

   task automatic t_psave(input logic slp, input int kind);
      logic seen;
      logic wen;
      logic men;
      int   n;
      wen = (kind != 2);
      men = (kind == 1);
      @(posedge clk);
      watchdog_timer_en        <= wen;
      clock_failure_monitor_en <= men;
      next_clock_source        <= 3'h5;
      repeat (2) @(posedge clk);
      power_save_instruction <= 1'b1;
      save_op_sleep          <= slp;
      @(posedge clk);
      power_save_instruction <= 1'b0;
      // the clear pulse stands only in the entry cycle
      #1 seen = wdt_clear_q;
      repeat (3) @(posedge clk);
      #1;
      check("wdt_clear", 32'(seen), 32'(wen));
      check("wdt_pulse", 32'(wdt_clear_q), 32'h0);
      check("halted", 32'(cpu_halted_q), 32'h1);
      check("osc_on", 32'(osc_enable_q), 32'(!slp));
      check("monitor", 32'(monitor_active_q), 32'(men & !slp));
      check("rc_on", 32'(low_power_rc_clock_en_q), 32'(slp ? wen : wen | men));
      @(posedge clk);
      next_clock_source <= 3'h2;
      measure(8);
      check("cpu_stopped", 32'(cpu_cnt), 32'h0);
      check("per_clk", 32'(per_cnt), slp ? 32'h0 : 32'd8);
      @(posedge clk);
      irq_pending <= (kind == 0);
      wdt_timeout <= (kind == 1);
      soft_reset  <= (kind == 2);
      n = 0;
      while (cpu_resume_q !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1 n++;
      end
      check("woke", 32'(n < 40), 32'h1);
      check("running", 32'(cpu_halted_q), 32'h0);
      check("osc_back", 32'(osc_enable_q), 32'h1);
      if (!slp && kind == 0) check("wake_lat", 32'(n - 1 >= 2 && n - 1 <= 4), 32'h1);
      if (slp) check("src_kept", 32'(clk_src_q), 32'h5);
      if (kind < 2) check("to_handler", 32'(resume_isr_q), 32'(kind == 0));
      @(posedge clk);
      irq_pending <= 1'b0;
      wdt_timeout <= 1'b0;
      soft_reset  <= 1'b0;
   endtask : t_psave

   task automatic t_coincide;
      logic slept;
      int   n;
      @(posedge clk);
      power_save_instruction <= 1'b1;
      save_op_sleep          <= 1'b1;
      @(posedge clk);
      power_save_instruction <= 1'b0;
      irq_pending            <= 1'b1;
      // one-cycle interrupt during entry: only the held request can wake
      @(posedge clk);
      irq_pending <= 1'b0;
      #1 slept = !osc_enable_q;
      n = 0;
      while (cpu_resume_q !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1 n++;
         slept = slept | !osc_enable_q;
      end
      check("entry_done", 32'(slept), 32'h1);
      check("late_wake", 32'(n < 40), 32'h1);
      check("to_handler", 32'(resume_isr_q), 32'h1);
      @(posedge clk);
   endtask : t_coincide

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_regs();
      t_map();
      t_clkstop();
      t_doze();
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < 3; k++) begin
            t_psave(s[0], k);
         end
      end
      t_coincide();
      wrap_up();
   end

   // the full sequence needs a few thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
endmodule : tb_power_save_clock_gating
